// ==== aer_apb_slave.sv ====
// apb handshake: one wait state per access
// assumes the master holds the request until pready is sampled high
`timescale 1ns/1ps
module aer_apb_slave (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   output logic pready,
   output logic take,
   output logic done
);
   aer_pkg::aer_apb_st_t state;

   // take marks the first access cycle, done the completing one
   assign take = (state == aer_pkg::APB_IDLE) && psel && penable;
   assign done = pready && psel && penable;

   // the wait state lets read data be registered before the answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= aer_pkg::APB_IDLE;
         pready <= 1'b0;
      end else begin
         case (state)
            aer_pkg::APB_IDLE: begin
               if (take) begin
                  state <= aer_pkg::APB_ACK;
                  pready <= 1'b1;
               end
            end
            aer_pkg::APB_ACK: begin
               state <= aer_pkg::APB_IDLE;
               pready <= 1'b0;
            end
            default: begin
               state <= aer_pkg::APB_IDLE;
               pready <= 1'b0;
            end
         endcase
      end
   end
endmodule : aer_apb_slave

// ==== aer_cfg.svh ====
// offsets, bit positions and reset values of the error register block
// assumes a 12-bit byte address on the register bus, 32-bit data
`ifndef AER_CFG_SVH
`define AER_CFG_SVH

// register byte offsets
`define AER_OFS_UNC_STS 12'h104
`define AER_OFS_UNC_MSK 12'h108
`define AER_OFS_UNC_SEV 12'h10c
`define AER_OFS_COR_STS 12'h110
`define AER_OFS_COR_MSK 12'h114
`define AER_OFS_CTL 12'h118
`define AER_OFS_HDR0 12'h11c
`define AER_OFS_HDR1 12'h120
`define AER_OFS_HDR2 12'h124
`define AER_OFS_HDR3 12'h128
`define AER_OFS_LOCK 12'h140
`define AER_OFS_IRQ_STS 12'h144
`define AER_OFS_IRQ_MSK 12'h148

// correctable status and mask bit positions
`define AER_COR_RCV 0
`define AER_COR_BADPKT 6
`define AER_COR_BADLNK 7
`define AER_COR_ROLL 8
`define AER_COR_RTO 12
`define AER_COR_ADV 13
`define AER_COR_VALID 32'h000031c1
`define AER_COR_MSK_RST 32'h00002000
`define AER_COR_STS_RST 32'h00000000

// uncorrectable positions handled here
`define AER_UNC_CRC 19
`define AER_UNC_UR 20
`define AER_UNC_SEV_RST 2'h0
`define AER_UNC_MSK_RST 2'h0

// control register fields
`define AER_CTL_PTR_LSB 0
`define AER_CTL_PTR_MSB 4
`define AER_CTL_GCAP 5
`define AER_CTL_GEN 6
`define AER_CTL_CCAP 7
`define AER_CTL_CEN 8
`define AER_CTL_CAP_RST 1'b1

// interrupt status and mask bits, lock bit
`define AER_IRQ_COR 0
`define AER_IRQ_NF 1
`define AER_IRQ_FAT 2
`define AER_IRQ_MSK_RST 3'h0
`define AER_LOCK_OPEN 0

`endif

// ==== aer_first_log.sv ====
// first error pointer and header capture for the uncorrectable events
// assumes events arrive already filtered by their mask bits
`timescale 1ns/1ps
`include "aer_cfg.svh"
module aer_first_log (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] log_evt,
   input wire logic [1:0] unc_sts,
   input wire logic [31:0] hdr_dw0,
   input wire logic [31:0] hdr_dw1,
   input wire logic [31:0] hdr_dw2,
   input wire logic [31:0] hdr_dw3,
   output logic [4:0] first_ptr,
   output logic [31:0] hdr_q0,
   output logic [31:0] hdr_q1,
   output logic [31:0] hdr_q2,
   output logic [31:0] hdr_q3
);
   logic [31:0] hdr_mem [4];
   logic held;
   logic ptr_sts;
   logic capture;
   logic [4:0] next_ptr;

   // a new capture only once the pointed status bit was cleared
   assign ptr_sts = (first_ptr == 5'(`AER_UNC_UR)) ? unc_sts[1] : unc_sts[0];
   assign capture = !held && (|log_evt);
   // lower position wins when both arrive together
   assign next_ptr = log_evt[0] ? 5'(`AER_UNC_CRC) : 5'(`AER_UNC_UR);
   assign hdr_q0 = hdr_mem[0];
   assign hdr_q1 = hdr_mem[1];
   assign hdr_q2 = hdr_mem[2];
   assign hdr_q3 = hdr_mem[3];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held <= 1'b0;
         first_ptr <= 5'h00;
         for (int i = 0; i < 4; i++) begin
            hdr_mem[i] <= 32'h00000000;
         end
      end else if (capture) begin
         held <= 1'b1;
         first_ptr <= next_ptr;
         hdr_mem[0] <= hdr_dw0;
         hdr_mem[1] <= hdr_dw1;
         hdr_mem[2] <= hdr_dw2;
         hdr_mem[3] <= hdr_dw3;
      end else if (held && !ptr_sts) begin
         held <= 1'b0;
      end
   end
endmodule : aer_first_log

// ==== aer_link_model.sv ====
// far-side detectors: one-cycle error events with header words
// assumes the bench asks for one event at a time by fire and sel
`timescale 1ns/1ps
module aer_link_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fire,
   input wire logic [2:0] sel,
   input wire logic [31:0] hdr_base,
   output logic [7:0] evt,
   output logic [31:0] hdr0,
   output logic [31:0] hdr1,
   output logic [31:0] hdr2,
   output logic [31:0] hdr3
);
   // header valid with pulse only
   // outside the pulse the words toggle so stale data never looks valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt <= 8'h00;
         hdr0 <= 32'h0;
         hdr1 <= 32'h0;
         hdr2 <= 32'h0;
         hdr3 <= 32'h0;
      end else begin
         evt <= fire ? (8'h01 << sel) : 8'h00;
         hdr0 <= fire ? hdr_base : ~hdr0;
         hdr1 <= fire ? hdr_base + 32'h1 : ~hdr1;
         hdr2 <= fire ? hdr_base + 32'h2 : ~hdr2;
         hdr3 <= fire ? hdr_base + 32'h3 : ~hdr3;
      end
   end
endmodule : aer_link_model

// ==== aer_pkg.sv ====
// types shared by the error register block
// constants live in aer_cfg.svh
package aer_pkg;
   typedef enum logic [0:0] {APB_IDLE, APB_ACK} aer_apb_st_t;
   typedef logic [31:0] aer_word_t;
   typedef logic [1:0] aer_pair_t;
endpackage : aer_pkg

// ==== aer_regs.sv ====
// error reporting registers: correctable status and mask, control,
// severity and mask of the crc and unsupported request events
// assumes detector events are one-cycle pulses on pclk, presetn is
// the power-on reset and hot_reset a synchronous level from logic
`timescale 1ns/1ps
`include "aer_cfg.svh"
module aer_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hot_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic receiver_error,
   input wire logic bad_packet,
   input wire logic bad_link_packet,
   input wire logic replay_count_rollover,
   input wire logic replay_timer_expired,
   input wire logic advisory_nonfatal,
   input wire logic crc_error,
   input wire logic unsupported_request,
   input wire logic [31:0] hdr_dw0,
   input wire logic [31:0] hdr_dw1,
   input wire logic [31:0] hdr_dw2,
   input wire logic [31:0] hdr_dw3,
   output logic report_correctable,
   output logic report_nonfatal,
   output logic report_fatal,
   output logic crc_gen_active,
   output logic crc_check_active,
   output logic irq
);
   // keeps the status, mask and severity layouts in one place
   // pick the two uncorrectable positions out of a word
   function automatic aer_pkg::aer_pair_t get_pair(input aer_pkg::aer_word_t w);
      get_pair = {w[`AER_UNC_UR], w[`AER_UNC_CRC]};
   endfunction : get_pair

   // place the two uncorrectable positions into a word
   function automatic aer_pkg::aer_word_t put_pair(input aer_pkg::aer_pair_t p);
      aer_pkg::aer_word_t w;
      w = 32'h00000000;
      w[`AER_UNC_CRC] = p[0];
      w[`AER_UNC_UR] = p[1];
      put_pair = w;
   endfunction : put_pair

   // internal state and next values
   logic take;
   logic done;
   logic wr;
   logic [31:0] rdata;
   logic [31:0] cor_sts;
   logic [31:0] cor_msk;
   logic [31:0] cor_evt;
   logic [31:0] next_cor_sts;
   logic [1:0] unc_sts;
   logic [1:0] unc_msk;
   logic [1:0] unc_sev;
   logic [1:0] unc_evt;
   logic [1:0] unc_live;
   logic [1:0] next_unc_sts;
   logic crc_gen_cap;
   logic crc_chk_cap;
   logic crc_gen_en;
   logic crc_chk_en;
   logic lock_open;
   logic [2:0] irq_sts;
   logic [2:0] irq_msk;
   logic [2:0] irq_cap;
   logic [2:0] irq_evt;
   logic [2:0] next_irq_sts;
   logic [4:0] first_ptr;
   logic [31:0] hdr_q0;
   logic [31:0] hdr_q1;
   logic [31:0] hdr_q2;
   logic [31:0] hdr_q3;
   logic [31:0] ctl_word;
   logic [31:0] lock_word;
   logic [31:0] irq_sts_word;
   logic [31:0] irq_msk_word;
   logic next_cor_rep;
   logic next_nf_rep;
   logic next_fat_rep;

   aer_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pready(pready),
      .take(take),
      .done(done)
   );

   // address decode
   // full 12-bit compare, so no register answers at an alias
   wire hit_unc_sts = (paddr == `AER_OFS_UNC_STS);
   wire hit_unc_msk = (paddr == `AER_OFS_UNC_MSK);
   wire hit_unc_sev = (paddr == `AER_OFS_UNC_SEV);
   wire hit_cor_sts = (paddr == `AER_OFS_COR_STS);
   wire hit_cor_msk = (paddr == `AER_OFS_COR_MSK);
   wire hit_ctl = (paddr == `AER_OFS_CTL);
   wire hit_hdr0 = (paddr == `AER_OFS_HDR0);
   wire hit_hdr1 = (paddr == `AER_OFS_HDR1);
   wire hit_hdr2 = (paddr == `AER_OFS_HDR2);
   wire hit_hdr3 = (paddr == `AER_OFS_HDR3);
   wire hit_lock = (paddr == `AER_OFS_LOCK);
   wire hit_irq_sts = (paddr == `AER_OFS_IRQ_STS);
   wire hit_irq_msk = (paddr == `AER_OFS_IRQ_MSK);
   wire map_hit = hit_unc_sts | hit_unc_msk | hit_unc_sev | hit_cor_sts | hit_cor_msk | hit_ctl |
                  hit_hdr0 | hit_hdr1 | hit_hdr2 | hit_hdr3 | hit_lock | hit_irq_sts | hit_irq_msk;

   // writes land on the completing edge only
   assign wr = done && pwrite;
   wire rd_irq_done = done && !pwrite && hit_irq_sts;

   // unused positions stay zero so reserved bits never set
   // receiver error position
   always_comb begin
      cor_evt = 32'h00000000;
      cor_evt[`AER_COR_RCV] = receiver_error;
      cor_evt[`AER_COR_BADPKT] = bad_packet;
      cor_evt[`AER_COR_BADLNK] = bad_link_packet;
      cor_evt[`AER_COR_ROLL] = replay_count_rollover;
      cor_evt[`AER_COR_RTO] = replay_timer_expired;
      cor_evt[`AER_COR_ADV] = advisory_nonfatal;
   end

   // write one clears
   // a detector pulse in the clearing cycle wins, so no event is lost
   wire [31:0] cor_clr = (wr && hit_cor_sts) ? (pwdata & `AER_COR_VALID) : 32'h00000000;
   assign next_cor_sts = (cor_sts & ~cor_clr) | cor_evt;

   // masked events still latch status but are not reported
   assign next_cor_rep = |(cor_evt & ~cor_msk);

   // the mask gates the event before status, pointer and log see it
   // masked events are dropped before logging
   assign unc_evt = {unsupported_request, crc_error};
   assign unc_live = unc_evt & ~unc_msk;
   wire [1:0] unc_clr = (wr && hit_unc_sts) ? get_pair(pwdata) : 2'h0;
   assign next_unc_sts = (unc_sts & ~unc_clr) | unc_live;

   // severity only steers the report, never what gets logged
   // crc severity picks fatal or non-fatal
   // request severity picks fatal or non-fatal
   assign next_fat_rep = |(unc_live & unc_sev);
   assign next_nf_rep = |(unc_live & ~unc_sev);

   // interrupt events follow the reports; read clears only what was read
   // capture at the access edge keeps a mid-read event from being lost
   assign irq_evt = {next_fat_rep, next_nf_rep, next_cor_rep};
   wire [2:0] irq_clr = rd_irq_done ? irq_cap : 3'h0;
   assign next_irq_sts = (irq_sts & ~irq_clr) | irq_evt;

   // capable bits shown as stored, whatever the lock state
   // pointer shown read-only in control
   always_comb begin
      ctl_word = 32'h00000000;
      ctl_word[`AER_CTL_PTR_MSB:`AER_CTL_PTR_LSB] = first_ptr;
      ctl_word[`AER_CTL_GCAP] = crc_gen_cap;
      ctl_word[`AER_CTL_GEN] = crc_gen_en;
      ctl_word[`AER_CTL_CCAP] = crc_chk_cap;
      ctl_word[`AER_CTL_CEN] = crc_chk_en;
   end

   // small own registers packed into the low bits
   // the lock is a plain bit; it guards only the capable bits
   assign lock_word = {31'h00000000, lock_open};
   assign irq_sts_word = {29'h00000000, irq_sts};
   assign irq_msk_word = {29'h00000000, irq_msk};

   // read selection; unmapped addresses read zero
   // one-hot decode lets an or-tree stand in for a case
   assign rdata = ({32{hit_unc_sts}} & put_pair(unc_sts)) |
                  ({32{hit_unc_msk}} & put_pair(unc_msk)) |
                  ({32{hit_unc_sev}} & put_pair(unc_sev)) |
                  ({32{hit_cor_sts}} & cor_sts) |
                  ({32{hit_cor_msk}} & cor_msk) |
                  ({32{hit_ctl}} & ctl_word) |
                  ({32{hit_hdr0}} & hdr_q0) |
                  ({32{hit_hdr1}} & hdr_q1) |
                  ({32{hit_hdr2}} & hdr_q2) |
                  ({32{hit_hdr3}} & hdr_q3) |
                  ({32{hit_lock}} & lock_word) |
                  ({32{hit_irq_sts}} & irq_sts_word) |
                  ({32{hit_irq_msk}} & irq_msk_word);

   // the log sees only live events, and the status for its release
   // first error pointer
   aer_first_log u_log (
      .pclk(pclk),
      .presetn(presetn),
      .log_evt(unc_live),
      .unc_sts(unc_sts),
      .hdr_dw0(hdr_dw0),
      .hdr_dw1(hdr_dw1),
      .hdr_dw2(hdr_dw2),
      .hdr_dw3(hdr_dw3),
      .first_ptr(first_ptr),
      .hdr_q0(hdr_q0),
      .hdr_q1(hdr_q1),
      .hdr_q2(hdr_q2),
      .hdr_q3(hdr_q3)
   );

   // bus answer: data and error registered on the first access edge
   // costs the wait state but keeps the read mux off the output path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         irq_cap <= 3'h0;
      end else if (take) begin
         prdata <= pwrite ? 32'h00000000 : rdata;
         pslverr <= !map_hit;
         irq_cap <= irq_sts;
      end else if (done) begin
         pslverr <= 1'b0;
      end
   end

   // hot_reset is left out of these flops on purpose
   // sticky group, power-on reset only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cor_sts <= `AER_COR_STS_RST;
         cor_msk <= `AER_COR_MSK_RST;
         unc_sts <= 2'h0;
         unc_msk <= `AER_UNC_MSK_RST;
         unc_sev <= `AER_UNC_SEV_RST;
         crc_gen_en <= 1'b0;
         crc_chk_en <= 1'b0;
      end else begin
         cor_sts <= next_cor_sts;
         unc_sts <= next_unc_sts;
         if (wr && hit_cor_msk) begin
            cor_msk <= pwdata & `AER_COR_VALID;
         end
         if (wr && hit_unc_msk) begin
            unc_msk <= get_pair(pwdata);
         end
         if (wr && hit_unc_sev) begin
            unc_sev <= get_pair(pwdata);
         end
         if (wr && hit_ctl) begin
            crc_gen_en <= pwdata[`AER_CTL_GEN];
            crc_chk_en <= pwdata[`AER_CTL_CEN];
         end
      end
   end

   // non-sticky group: also returned to defaults by hot reset
   // hot reset wins over a write landing in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_gen_cap <= `AER_CTL_CAP_RST;
         crc_chk_cap <= `AER_CTL_CAP_RST;
         lock_open <= 1'b0;
         irq_sts <= 3'h0;
         irq_msk <= `AER_IRQ_MSK_RST;
      end else if (hot_reset) begin
         crc_gen_cap <= `AER_CTL_CAP_RST;
         crc_chk_cap <= `AER_CTL_CAP_RST;
         lock_open <= 1'b0;
         irq_sts <= 3'h0;
         irq_msk <= `AER_IRQ_MSK_RST;
      end else begin
         irq_sts <= next_irq_sts;
         if (wr && hit_lock) begin
            lock_open <= pwdata[`AER_LOCK_OPEN];
         end
         if (wr && hit_irq_msk) begin
            irq_msk <= pwdata[2:0];
         end
         if (wr && hit_ctl && lock_open) begin
            crc_gen_cap <= pwdata[`AER_CTL_GCAP];
            crc_chk_cap <= pwdata[`AER_CTL_CCAP];
         end
      end
   end

   // report pulses, crc controls and interrupt line, all registered; reports one cycle
   // behind the event, the interrupt line two, as it follows irq status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         report_correctable <= 1'b0;
         report_nonfatal <= 1'b0;
         report_fatal <= 1'b0;
         crc_gen_active <= 1'b0;
         crc_check_active <= 1'b0;
         irq <= 1'b0;
      end else begin
         report_correctable <= next_cor_rep;
         report_nonfatal <= next_nf_rep;
         report_fatal <= next_fat_rep;
         crc_gen_active <= crc_gen_en && crc_gen_cap;
         crc_check_active <= crc_chk_en && crc_chk_cap;
         irq <= |(irq_sts & ~irq_msk);
      end
   end
endmodule : aer_regs

// ==== aer_regs_properties.sv ====
// port assertions for the error register block
// assumes one pclk domain, presetn as power-on reset
`timescale 1ns/1ps
module aer_regs_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hot_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic receiver_error,
   input wire logic bad_packet,
   input wire logic bad_link_packet,
   input wire logic replay_count_rollover,
   input wire logic replay_timer_expired,
   input wire logic advisory_nonfatal,
   input wire logic crc_error,
   input wire logic unsupported_request,
   input wire logic report_correctable,
   input wire logic report_nonfatal,
   input wire logic report_fatal,
   input wire logic crc_gen_active,
   input wire logic crc_check_active,
   input wire logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // decoded causes; writes land on the pready edge
   wire logic cor_evt = receiver_error | bad_packet | bad_link_packet | replay_count_rollover
      | replay_timer_expired | advisory_nonfatal;
   wire logic unc_evt = crc_error | unsupported_request;
   wire logic acc = psel & penable;
   wire logic ctl_wr = acc & pready & pwrite & (paddr == 12'h118);
   wire logic irq_kick = (acc & pready & pwrite & (paddr == 12'h148)) | hot_reset;
   wire logic any_rep = report_correctable | report_nonfatal | report_fatal;
   wire logic rd_ok = pready & ~pwrite & ~pslverr;
   sequence access_s;
      acc && !pready;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence
   one_wait_a: assert property (access_s |=> answer_s) else $error("apb answer not after one wait state");
   err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error answer malformed");
   fatal_cause_a: assert property (report_fatal |-> $past(unc_evt)) else $error("fatal report without event");
   nonfatal_cause_a: assert property (report_nonfatal |-> $past(unc_evt)) else $error("nonfatal without event");
   cor_cause_a: assert property (report_correctable |-> $past(cor_evt)) else $error("correctable report without event");
   cor_rsvd_a: assert property (rd_ok && paddr == 12'h110 |-> (prdata & ~32'h000031c1) == 32'h0)
      else $error("status reserved bits set");
   ctl_read_a: assert property (rd_ok && paddr == 12'h118 |-> prdata[31:9] == 23'h0
      && prdata[4:0] inside {5'd0, 5'd19, 5'd20}) else $error("control read malformed");
   gen_hold_a: assert property ($changed(crc_gen_active) |-> $past(ctl_wr) || $past(ctl_wr, 2)
      || $past(hot_reset) || $past(hot_reset, 2)) else $error("generation changed without cause");
   chk_hold_a: assert property ($changed(crc_check_active) |-> $past(ctl_wr) || $past(ctl_wr, 2)
      || $past(hot_reset) || $past(hot_reset, 2)) else $error("checking changed without cause");
   irq_cause_a: assert property ($rose(irq) |-> $past(any_rep) || $past(irq_kick) || $past(irq_kick, 2))
      else $error("interrupt rose without cause");
endmodule : aer_regs_chk
bind aer_regs aer_regs_chk u_chk (.pclk, .presetn, .hot_reset, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .receiver_error, .bad_packet, .bad_link_packet, .replay_count_rollover,
   .replay_timer_expired, .advisory_nonfatal, .crc_error, .unsupported_request, .report_correctable,
   .report_nonfatal, .report_fatal, .crc_gen_active, .crc_check_active, .irq);

// ==== pcie_aer_correctable_and_control_tb.sv ====
// self-checking bench for the error register block
// apb master plus the link model as event source
`timescale 1ns/1ps
module pcie_aer_correctable_and_control_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic hot_reset = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic fire = 1'b0;
   logic [2:0] sel = 3'h0;
   logic [31:0] hdr_base = 32'h0;
   logic [31:0] rd, r;
   logic err;
   int bad_count = 0;
   int checks_done = 0;
   wire [31:0] prdata, h0, h1, h2, h3;
   wire [7:0] evt;
   wire pready, pslverr, report_correctable, report_nonfatal, report_fatal, crc_gen_active, crc_check_active, irq;
   // 100 MHz
   always #5 pclk = ~pclk;
   aer_link_model u_link (.pclk, .presetn, .fire, .sel, .hdr_base, .evt, .hdr0(h0), .hdr1(h1), .hdr2(h2), .hdr3(h3));
   aer_regs u_dut (.pclk, .presetn, .hot_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .receiver_error(evt[0]), .bad_packet(evt[1]), .bad_link_packet(evt[2]),
      .replay_count_rollover(evt[3]), .replay_timer_expired(evt[4]), .advisory_nonfatal(evt[5]),
      .crc_error(evt[6]), .unsupported_request(evt[7]), .hdr_dw0(h0), .hdr_dw1(h1), .hdr_dw2(h2), .hdr_dw3(h3),
      .report_correctable, .report_nonfatal, .report_fatal, .crc_gen_active, .crc_check_active, .irq);
   // expected status bit of each correctable source
   function automatic logic [31:0] cor_bit(input int k);
      logic [31:0] t [6];
      t = '{32'h1, 32'h40, 32'h80, 32'h100, 32'h1000, 32'h2000};
      return t[k];
   endfunction : cor_bit
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // request held until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n == 20) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask : rdchk
   // one event; returns once its report has settled
   task automatic hit(input int s);
      @(posedge pclk);
      fire <= 1'b1;
      sel <= s[2:0];
      hdr_base <= $urandom;
      @(posedge pclk);
      fire <= 1'b0;
      @(posedge pclk);
      #1;
   endtask : hit
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   // run length is a few hundred cycles; this cuts a hang
   initial begin
      #200000;
      bad_count++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h7389d028));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("cor status", 12'h110, 32'h0);
      rdchk("cor mask", 12'h114, 32'h2000);
      rdchk("control", 12'h118, 32'h0a0);
      rdchk("severity", 12'h10c, 32'h0);
      // every correctable source; advisory is masked out of reset
      for (int i = 0; i < 6; i++) begin
         hit(i);
         chk("cor report", 32'(report_correctable), 32'(i != 5));
         apb(1'b1, 12'h110, 32'h0);
         rdchk("cor bit", 12'h110, cor_bit(i));
         apb(1'b1, 12'h110, cor_bit(i));
         rdchk("cor clear", 12'h110, 32'h0);
      end
      repeat (4) begin
         r = $urandom;
         apb(1'b1, 12'h114, r);
         rdchk("mask rw", 12'h114, r & 32'h000031c1);
      end
      apb(1'b1, 12'h114, 32'h1);
      hit(0);
      chk("masked report", 32'(report_correctable), 32'h0);
      rdchk("masked status", 12'h110, 32'h1);
      apb(1'b1, 12'h114, 32'h0);
      hit(5);
      chk("advisory report", 32'(report_correctable), 32'h1);
      // capable bits hold while locked, enables take effect
      apb(1'b1, 12'h118, 32'h140);
      rdchk("ctl locked", 12'h118, 32'h1e0);
      chk("active on", {crc_gen_active, crc_check_active}, 32'h3);
      apb(1'b1, 12'h140, 32'h1);
      apb(1'b1, 12'h118, 32'h140);
      rdchk("ctl open", 12'h118, 32'h140);
      chk("active off", {crc_gen_active, crc_check_active}, 32'h0);
      @(posedge pclk) hot_reset <= 1'b1;
      @(posedge pclk) hot_reset <= 1'b0;
      rdchk("ctl hot", 12'h118, 32'h1e0);
      rdchk("sts hot", 12'h110, 32'h2001);
      chk("active hot", {crc_gen_active, crc_check_active}, 32'h3);
      // severity and first error log
      apb(1'b1, 12'h10c, 32'hffffffff);
      rdchk("sev", 12'h10c, 32'h00180000);
      hit(6);
      r = hdr_base;
      chk("crc fatal", {report_fatal, report_nonfatal}, 32'h2);
      apb(1'b1, 12'h10c, 32'h00080000);
      hit(7);
      chk("ur nonfatal", {report_fatal, report_nonfatal}, 32'h1);
      rdchk("pointer", 12'h118, 32'h1e0 | 32'd19);
      rdchk("hdr first", 12'h11c, r);
      rdchk("hdr last", 12'h128, r + 32'h3);
      apb(1'b1, 12'h108, 32'h00100000);
      hit(7);
      chk("ur masked", {report_fatal, report_nonfatal}, 32'h0);
      // clearing the pointed status frees the log for the next event
      rdchk("unc sts", 12'h104, 32'h00180000);
      apb(1'b1, 12'h104, 32'h00080000);
      apb(1'b1, 12'h108, 32'h0);
      hit(7);
      r = hdr_base;
      rdchk("pointer again", 12'h118, 32'h1e0 | 32'd20);
      rdchk("hdr again", 12'h11c, r);
      apb(1'b0, 12'h200, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      // interrupt: mask, unmask, read clears
      apb(1'b1, 12'h148, 32'h7);
      repeat (2) @(posedge pclk);
      #1;
      chk("irq masked", 32'(irq), 32'h0);
      apb(1'b1, 12'h148, 32'h0);
      repeat (2) @(posedge pclk);
      #1;
      chk("irq on", 32'(irq), 32'h1);
      // only fatal and non-fatal events came after the hot reset
      rdchk("irq sts", 12'h144, 32'h6);
      repeat (2) @(posedge pclk);
      #1;
      chk("irq clear", 32'(irq), 32'h0);
      finish_test();
   end
endmodule : pcie_aer_correctable_and_control_tb
